//--- dv/iowed_chk.sv
// port assertions for the i/o window end-address decoder
`timescale 1ns/1ps
`default_nettype none
module iowed_chk (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   cyc_i,
  input wire logic                   stb_i,
  input wire logic                   ack_o,
  input wire logic [31:0]            dat_o,
  input wire logic                   io_req_i,
  input wire iowed_pkg::iowed_addr_t io_addr_i,
  input wire logic                   io_done_o,
  input wire logic                   io_fwd_o,
  input wire logic                   io_win_o,
  input wire iowed_pkg::iowed_addr_t io_card_addr_o
);
  import iowed_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////////
  // bus answer timing and read data shape
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_dat_upper: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  // decode answer timing and miss results
  a_done_next: assert property (io_req_i |=> io_done_o)
    else $error("decode done missing");
  a_done_cause: assert property (io_done_o |-> $past(io_req_i))
    else $error("decode done without request");
  a_miss_addr: assert property (io_done_o && !io_fwd_o |-> !io_win_o
    && io_card_addr_o == $past(io_addr_i))
    else $error("miss result not host address");
  a_win_fwd: assert property (io_done_o && io_win_o |-> io_fwd_o)
    else $error("window one reported without forward");
  a_result_hold: assert property (!io_done_o |-> $stable(io_card_addr_o)
    && $stable(io_fwd_o))
    else $error("decode result changed without request");
  a_reset_clear: assert property (disable iff (1'h0) rst_i |=> !ack_o
    && !io_done_o && !io_fwd_o)
    else $error("outputs not cleared by reset");
endmodule
bind iowed_top iowed_chk u_iowed_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o), .io_req_i(io_req_i), .io_addr_i(io_addr_i),
  .io_done_o(io_done_o), .io_fwd_o(io_fwd_o), .io_win_o(io_win_o),
  .io_card_addr_o(io_card_addr_o));
`default_nettype wire

//--- dv/iowed_host.sv
// host software model: classic wishbone master for the socket registers
`timescale 1ns/1ps
`default_nettype none
module iowed_host (
  input wire logic         clk_i,
  input wire logic         ack_i,
  input wire logic [31:0]  dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [3:0]       sel_o,
  output logic [9:0]       adr_o,
  output logic [31:0]      dat_o
);
  // idle bus at time zero
  initial begin
    {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} = '0;
  end
  // one transfer, held until ack is sampled; released lines show garbage
  task automatic xfer(input logic [9:0] a, input logic w, input logic [7:0] d,
                      output logic [31:0] q, output bit to);
    int n;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, sel_o, adr_o} <= {1'h1, 1'h1, w, 4'h1, a};
    dat_o <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'h1 && n < 20);
    q = dat_i;
    to = (ack_i !== 1'h1);
    {cyc_o, stb_o, we_o, adr_o} <= {1'h0, 1'h0, 1'h0, ~a};
    dat_o <= ~{24'h000000, d};
  endtask
endmodule
`default_nettype wire

//--- dv/test_iowed_top.sv
// bench for the i/o window end-address decoder
`timescale 1ns/1ps
`default_nettype none
module test_iowed_top;
  import iowed_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, io_req, io_sock, io_done, io_fwd, io_win;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  iowed_addr_t io_addr, card;
  int          num_errors, n_checks;
  localparam logic [5:0] ENDS [4] = '{IDX_W0_END_LO, IDX_W0_END_HI, IDX_W1_END_LO,
                                      IDX_W1_END_HI};
  iowed_top u_iowed_top (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
    .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
    .io_req_i(io_req), .io_sock_i(io_sock), .io_addr_i(io_addr), .io_done_o(io_done),
    .io_fwd_o(io_fwd), .io_win_o(io_win), .io_card_addr_o(card));
  iowed_host u_iowed_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat));
  // 40 mhz clock
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  // verdict, compare and access tasks
  task results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  function automatic logic [9:0] ra(input logic s, input logic [5:0] i);
    return {1'h0, s, i, 2'h0};
  endfunction
  task acc(input logic [9:0] a, input logic w, input logic [7:0] d, input logic [7:0] e);
    logic [31:0] q;
    bit to;
    u_iowed_host.xfer(a, w, d, q, to);
    if (to) begin
      num_errors++;
      results();
    end else if (!w) begin
      chk(q, {24'h000000, e});
    end
  endtask
  task io(input logic s, input iowed_addr_t a, input logic f, input logic w,
          input iowed_addr_t c);
    @(posedge clk_i);
    {io_req, io_sock, io_addr} <= {1'h1, s, a};
    @(posedge clk_i);
    {io_req, io_addr} <= {1'h0, ~a};
    #1;
    chk(io_done, 1'h1);
    chk({io_fwd, io_win, card}, {f, w, c});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_i, io_req, io_sock, io_addr} = {1'h1, 1'h0, 1'h0, 16'h0000};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    for (int s = 0; s < 2; s++) for (int k = 0; k < 4; k++)
      acc(ra(s[0], ENDS[k]), 1'h0, 8'h00, RST_BYTE);
    io(1'h0, 16'h0000, 1'h0, 1'h0, 16'h0000);
    $display("test reset done");
    for (int k = 0; k < 4; k++) acc(ra(1'h0, ENDS[k]), 1'h1, 8'hA0 + k, 8'h00);
    for (int k = 0; k < 4; k++) begin
      acc(ra(1'h0, ENDS[k]), 1'h0, 8'h00, 8'hA0 + k);
      acc(ra(1'h1, ENDS[k]), 1'h0, 8'h00, RST_BYTE);
    end
    acc(ra(1'h0, 6'h20), 1'h1, 8'h5A, 8'h00);
    acc(ra(1'h0, 6'h20), 1'h0, 8'h00, 8'h00);
    acc(10'h228, 1'h0, 8'h00, 8'h00);
    $display("test regs done");
    acc(ra(0, IDX_W0_START_LO), 1, 8'h34, 0);
    acc(ra(0, IDX_W0_START_HI), 1, 8'h12, 0);
    acc(ra(0, IDX_W0_END_LO), 1, 8'h80, 0);
    acc(ra(0, IDX_W0_END_HI), 1, 8'h12, 0);
    acc(ra(0, IDX_W0_OFS_LO), 1, 8'h00, 0);
    acc(ra(0, IDX_W0_OFS_HI), 1, 8'h01, 0);
    acc(ra(0, IDX_WIN_ENABLE), 1, 8'h01, 0);
    io(1'h0, 16'h1234, 1'h1, 1'h0, 16'h1334);
    io(1'h0, 16'h1233, 1'h0, 1'h0, 16'h1233);
    io(1'h0, 16'h1280, 1'h1, 1'h0, 16'h1380);
    io(1'h0, 16'h1281, 1'h0, 1'h0, 16'h1281);
    io(1'h0, 16'h1334, 1'h0, 1'h0, 16'h1334);
    acc(ra(0, IDX_W1_START_HI), 1, 8'h20, 0);
    acc(ra(0, IDX_W1_END_LO), 1, 8'hFF, 0);
    acc(ra(0, IDX_W1_END_HI), 1, 8'h20, 0);
    acc(ra(0, IDX_W1_OFS_LO), 1, 8'hF0, 0);
    acc(ra(0, IDX_W1_OFS_HI), 1, 8'hFF, 0);
    acc(ra(0, IDX_WIN_ENABLE), 1, 8'h03, 0);
    io(1'h0, 16'h20FF, 1'h1, 1'h1, 16'h20EF);
    io(1'h0, 16'h2100, 1'h0, 1'h0, 16'h2100);
    acc(ra(1, IDX_WIN_ENABLE), 1, 8'h01, 0);
    io(1'h1, 16'h1240, 1'h0, 1'h0, 16'h1240);
    io(1'h1, 16'h0000, 1'h1, 1'h0, 16'h0000);
    $display("test decode done");
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    acc(ra(1'h0, IDX_W0_END_HI), 1'h0, 8'h00, RST_BYTE);
    io(1'h0, 16'h1234, 1'h0, 1'h0, 16'h1234);
    $display("test rereset done");
    results();
  end
endmodule
`default_nettype wire

//--- logic/iowed_pkg.sv
// constants, types and register map of the i/o window end-address decoder
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - forward host i/o access when start <= address <= end, both inclusive
// - end-address low bytes, read/write, index 0Ah and 0Eh, reset zero
// - end-address high bytes 15-8, read/write, index 0Bh and 0Fh, reset zero
// - low end byte supplies bits 7-0 of the compared end address
// - high and low end bytes together form the full inclusive end bound
// - start address low at 08h/0Ch, high at 09h/0Dh per window
// - forwarded access adds the window card offset to host i/o address
//////////////////////////////////////////////////////////////////////////////
package iowed_pkg;

  // geometry
  localparam int NUM_SOCK = 2;
  localparam int NUM_WIN  = 2;
  localparam int NUM_ENT  = NUM_SOCK * NUM_WIN;

  // wishbone byte address: index times four, index bit 6 picks the socket
  localparam int ADR_W     = 10;
  localparam int IDX_LSB   = 2;
  localparam int IDX_SOCK  = 8;  // adr bit of socket select (index bit 6)
  localparam int IDX_TOP   = 9;  // adr bit that must be zero (index bit 7)

  // per-socket register indexes (low six index bits)
  localparam logic [5:0] IDX_W0_START_LO = 6'h08;
  localparam logic [5:0] IDX_W0_START_HI = 6'h09;
  localparam logic [5:0] IDX_W0_END_LO   = 6'h0A;
  localparam logic [5:0] IDX_W0_END_HI   = 6'h0B;
  localparam logic [5:0] IDX_W1_START_LO = 6'h0C;
  localparam logic [5:0] IDX_W1_START_HI = 6'h0D;
  localparam logic [5:0] IDX_W1_END_LO   = 6'h0E;
  localparam logic [5:0] IDX_W1_END_HI   = 6'h0F;
  localparam logic [5:0] IDX_W0_OFS_LO   = 6'h36;
  localparam logic [5:0] IDX_W0_OFS_HI   = 6'h37;
  localparam logic [5:0] IDX_W1_OFS_LO   = 6'h38;
  localparam logic [5:0] IDX_W1_OFS_HI   = 6'h39;
  localparam logic [5:0] IDX_WIN_ENABLE  = 6'h3A;
  localparam logic [5:0] IDX_HIT_STATUS  = 6'h3B;
  localparam logic [5:0] IDX_LAST_LO     = 6'h3C;
  localparam logic [5:0] IDX_LAST_HI     = 6'h3D;

  // reset values and field masks
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [1:0] RST_ENABLE  = 2'h0;
  localparam logic [2:0] RST_STATUS  = 3'h0;
  localparam logic [7:0] OFS_LO_MASK = 8'hFE;  // offset bit 0 always zero

  // hit status fields
  localparam int ST_HIT0 = 0;
  localparam int ST_HIT1 = 1;
  localparam int ST_FWD  = 2;

  typedef logic [15:0] iowed_addr_t;
  typedef logic [7:0]  iowed_byte_t;

endpackage

//--- logic/iowed_top.sv
// register bank and decoder for the two system i/o windows of each socket
`timescale 1ns/1ps
`default_nettype none
module iowed_top (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // wishbone classic slave
  input  wire logic [iowed_pkg::ADR_W-1:0] adr_i,
  input  wire logic [31:0]               dat_i,
  output logic      [31:0]               dat_o,
  input  wire logic                      we_i,
  input  wire logic [3:0]                sel_i,
  input  wire logic                      cyc_i,
  input  wire logic                      stb_i,
  output logic                           ack_o,
  // host i/o access to decode
  input  wire logic                      io_req_i,
  input  wire logic                      io_sock_i,
  input  wire iowed_pkg::iowed_addr_t    io_addr_i,
  // decode result, one cycle after the request
  output logic                           io_done_o,
  output logic                           io_fwd_o,
  output logic                           io_win_o,
  output iowed_pkg::iowed_addr_t         io_card_addr_o
);
  import iowed_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // bus request decode

  logic        ack_ff;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;

  wire         bus_req  = cyc_i & stb_i;
  wire         bus_new  = bus_req & ~ack_ff;       // first cycle of a request
  // write lands at the acknowledging edge, while the master still holds it
  wire         wr_en    = bus_req & ack_ff & we_i & sel_i[0];
  wire         idx_sock = adr_i[IDX_SOCK];
  wire         idx_ok   = ~adr_i[IDX_TOP];
  wire [5:0]   idx_reg  = adr_i[IDX_SOCK-1:IDX_LSB];
  wire [7:0]   wb_byte  = dat_i[7:0];

  //////////////////////////////////////////////////////////////////////////
  // per-entry window registers and decoders

  logic        ent_hit  [NUM_ENT];
  iowed_addr_t ent_card [NUM_ENT];
  iowed_byte_t ent_rd   [NUM_ENT];
  logic [1:0]  win_en_ff [NUM_SOCK];

  genvar e;
  generate
    for (e = 0; e < NUM_ENT; e++) begin : g_ent
      localparam logic SOCK = 1'((e / NUM_WIN) % 2);
      localparam int   WIN  = e % NUM_WIN;
      localparam logic [5:0] I_SLO = (WIN == 0) ? IDX_W0_START_LO : IDX_W1_START_LO;
      localparam logic [5:0] I_SHI = (WIN == 0) ? IDX_W0_START_HI : IDX_W1_START_HI;
      localparam logic [5:0] I_ELO = (WIN == 0) ? IDX_W0_END_LO : IDX_W1_END_LO;
      localparam logic [5:0] I_EHI = (WIN == 0) ? IDX_W0_END_HI : IDX_W1_END_HI;
      localparam logic [5:0] I_OLO = (WIN == 0) ? IDX_W0_OFS_LO : IDX_W1_OFS_LO;
      localparam logic [5:0] I_OHI = (WIN == 0) ? IDX_W0_OFS_HI : IDX_W1_OFS_HI;

      iowed_byte_t slo_ff;
      iowed_byte_t shi_ff;
      iowed_byte_t elo_ff;
      iowed_byte_t ehi_ff;
      iowed_byte_t olo_ff;
      iowed_byte_t ohi_ff;

      // this entry belongs to the addressed socket
      wire mine  = idx_ok & (idx_sock == SOCK);
      wire wr_me = wr_en & mine;

      // start bytes
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          slo_ff <= RST_BYTE;
          shi_ff <= RST_BYTE;
        end else begin
          if (wr_me && idx_reg == I_SLO) slo_ff <= wb_byte;
          if (wr_me && idx_reg == I_SHI) shi_ff <= wb_byte;
        end
      end

      // end bytes
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          elo_ff <= RST_BYTE;
          ehi_ff <= RST_BYTE;
        end else begin
          if (wr_me && idx_reg == I_ELO) elo_ff <= wb_byte;
          if (wr_me && idx_reg == I_EHI) ehi_ff <= wb_byte;
        end
      end

      // card offset bytes, bit 0 of the low byte held at zero
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          olo_ff <= RST_BYTE;
          ohi_ff <= RST_BYTE;
        end else begin
          if (wr_me && idx_reg == I_OLO) olo_ff <= wb_byte & OFS_LO_MASK;
          if (wr_me && idx_reg == I_OHI) ohi_ff <= wb_byte;
        end
      end

      // register read-back for this entry
      assign ent_rd[e] = !mine                ? RST_BYTE :
                         (idx_reg == I_SLO)   ? slo_ff :
                         (idx_reg == I_SHI)   ? shi_ff :
                         (idx_reg == I_ELO)   ? elo_ff :
                         (idx_reg == I_EHI)   ? ehi_ff :
                         (idx_reg == I_OLO)   ? olo_ff :
                         (idx_reg == I_OHI)   ? ohi_ff : RST_BYTE;

      // assembled bounds: high byte over low byte
      wire iowed_addr_t start_w = {shi_ff, slo_ff};
      wire iowed_addr_t end_w   = {ehi_ff, elo_ff};
      wire iowed_addr_t ofs_w   = {ohi_ff, olo_ff};

      iowed_win u_win (
        .en_i        (win_en_ff[SOCK][WIN]),
        .start_i     (start_w),
        .end_i       (end_w),
        .ofs_i       (ofs_w),
        .addr_i      (io_addr_i),
        .hit_o       (ent_hit[e]),
        .card_addr_o (ent_card[e])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // per-socket enable, status and last card address

  logic [2:0]  status_ff [NUM_SOCK];
  iowed_addr_t last_ff   [NUM_SOCK];
  iowed_byte_t sock_rd   [NUM_SOCK];

  // decode of the requested socket only
  wire         hit0   = ent_hit[{io_sock_i, 1'b0}];
  wire         hit1   = ent_hit[{io_sock_i, 1'b1}];
  wire         fwd    = hit0 | hit1;
  wire         win_w  = ~hit0 & hit1;                // window 0 wins an overlap
  wire iowed_addr_t card_w = hit0 ? ent_card[{io_sock_i, 1'b0}] :
                                    ent_card[{io_sock_i, 1'b1}];

  genvar s;
  generate
    for (s = 0; s < NUM_SOCK; s++) begin : g_sock
      localparam logic SOCK = 1'(s % 2);
      wire mine   = idx_ok & (idx_sock == SOCK);
      wire req_me = io_req_i & (io_sock_i == SOCK);

      // window enable bits
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          win_en_ff[s] <= RST_ENABLE;
        end else if (wr_en && mine && idx_reg == IDX_WIN_ENABLE) begin
          win_en_ff[s] <= wb_byte[1:0];
        end
      end

      // status of the socket's latest decode, card address of its latest forwarded decode
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          status_ff[s] <= RST_STATUS;
          last_ff[s]   <= {RST_BYTE, RST_BYTE};
        end else if (req_me) begin
          status_ff[s] <= {fwd, hit1, hit0};
          if (fwd) last_ff[s] <= card_w;
        end
      end

      // read-back of socket-level registers
      assign sock_rd[s] = !mine                        ? RST_BYTE :
                          (idx_reg == IDX_WIN_ENABLE)  ? {6'h00, win_en_ff[s]} :
                          (idx_reg == IDX_HIT_STATUS)  ? {5'h00, status_ff[s]} :
                          (idx_reg == IDX_LAST_LO)     ? last_ff[s][7:0] :
                          (idx_reg == IDX_LAST_HI)     ? last_ff[s][15:8] : RST_BYTE;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // read data merge: at most one source is non-zero

  always_comb begin
    iowed_byte_t rd;
    rd = RST_BYTE;
    for (int i = 0; i < NUM_ENT; i++) begin
      rd = rd | ent_rd[i];
    end
    for (int j = 0; j < NUM_SOCK; j++) begin
      rd = rd | sock_rd[j];
    end
    nxt_dat = {24'h000000, rd};
  end

  //////////////////////////////////////////////////////////////////////////
  // bus answer: one wait state, ack for one cycle

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= bus_new;
      if (bus_new && !we_i) dat_ff <= nxt_dat;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  //////////////////////////////////////////////////////////////////////////
  // decode result registers

  logic        done_ff;
  logic        fwd_ff;
  logic        win_ff;
  iowed_addr_t card_ff;

  // result held until the next request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_ff <= 1'b0;
      fwd_ff  <= 1'b0;
      win_ff  <= 1'b0;
      card_ff <= {RST_BYTE, RST_BYTE};
    end else begin
      done_ff <= io_req_i;
      if (io_req_i) begin
        fwd_ff  <= fwd;
        win_ff  <= win_w;
        card_ff <= fwd ? card_w : io_addr_i;
      end
    end
  end

  assign io_done_o      = done_ff;
  assign io_fwd_o       = fwd_ff;
  assign io_win_o       = win_ff;
  assign io_card_addr_o = card_ff;

endmodule
`default_nettype wire

//--- logic/iowed_win.sv
// one i/o window: inclusive range compare and card address offset
`timescale 1ns/1ps
`default_nettype none
module iowed_win (
  input  wire logic               en_i,
  input  wire iowed_pkg::iowed_addr_t start_i,
  input  wire iowed_pkg::iowed_addr_t end_i,
  input  wire iowed_pkg::iowed_addr_t ofs_i,
  input  wire iowed_pkg::iowed_addr_t addr_i,
  output logic                    hit_o,
  output iowed_pkg::iowed_addr_t  card_addr_o
);
  import iowed_pkg::*;

  // both bounds inclusive, full 16-bit compare
  assign hit_o = en_i && (addr_i >= start_i) && (addr_i <= end_i);

  // card address wraps at 16 bits
  assign card_addr_o = addr_i + ofs_i;
endmodule
`default_nettype wire
